// ### design/ifr_pkg.sv
// Constants, register map and state type for the interrupt flag and reset entry block.
// Assumes one 20 MHz system clock and a simple strobe register port.
package ifr_pkg;

	// =====================================================================
	// Bus geometry and pin counts
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PIN_IRQS = 4;
	localparam int WAKE_PINS = 6;

	// =====================================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_REQUEST_FLAGS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_WAKEUP_FLAGS = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 4'h3;

	// =====================================================================
	// Field positions of the main flag register
	localparam int BIT_DIRECT_TRANSITION = 7;
	localparam int BIT_TIMER_OVERFLOW = 6;
	localparam int BIT_RSVD_HI = 5;
	localparam int BIT_RSVD_LO = 4;

	// Field positions of the event status and mask registers
	localparam int BIT_EVT_SEQ_DONE = 0;
	localparam int BIT_EVT_SHORT_RESET = 1;
	localparam int EVT_BITS = 2;

	// =====================================================================
	// Reset values
	localparam logic [DATA_W-1:0] RST_FLAGS = 8'h00;
	localparam logic [1:0] RSVD_READ_ONES = 2'h3;
	localparam logic [EVT_BITS-1:0] RST_EVENTS = 2'h0;

	// =====================================================================
	// Reset entry timing and vector
	localparam int RESET_MIN_CYCLES = 10;
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
	localparam logic [15:0] RST_PC = 16'h0000;

	typedef enum logic [2:0] {
		SEQ_RESET,
		SEQ_MASK,
		SEQ_VEC_REQ,
		SEQ_VEC_WAIT,
		SEQ_FIRST,
		SEQ_RUN
	} ifr_seq_state_e;

endpackage

// ### design/ifr_seq_if.sv
// Signals between the reset entry sequencer and the flag block top.
// Assumes both ends sit on the same system clock.
`timescale 1ns/100ps
interface ifr_seq_if;
	logic hold;
	logic init;
	logic mask_set;
	logic vec_rd;
	logic pc_load;
	logic [15:0] pc_value;
	logic irq_block;
	logic seq_done;
	logic short_reset;
	logic [15:0] vec_data;
	logic vec_valid;
	logic first_done;

	modport seq (
		output hold, init, mask_set, vec_rd, pc_load, pc_value, irq_block,
		output seq_done, short_reset,
		input vec_data, vec_valid, first_done
	);
	modport top (
		input hold, init, mask_set, vec_rd, pc_load, pc_value, irq_block,
		input seq_done, short_reset,
		output vec_data, vec_valid, first_done
	);
endinterface

// ### design/ifr_pin_edge.sv
// Synchronises one interrupt pin and flags its selected edge.
// Assumes the pin is asynchronous to the system clock.
`timescale 1ns/100ps
module ifr_pin_edge (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Pin and edge choice
	input wire logic pin_i,
	input wire logic rise_sel_i,
	// Detected edge, one cycle
	output logic edge_o
);
	logic s1;
	logic s2;
	logic s3;
	logic level;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A change is taken only once stages two and three agree.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			level <= 1'b1;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end

	always_comb begin
		edge_o = 1'b0;
		if (s2 == s3 && s3 != level) begin
			edge_o = (s3 == rise_sel_i);
		end
	end
endmodule // ifr_pin_edge

// ### design/ifr_reset_seq.sv
// Reset pin watcher and reset exception sequencer.
// Assumes the CPU answers a vector read with one vec_valid pulse.
`timescale 1ns/100ps
module ifr_reset_seq (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Reset pin, active low
	input wire logic reset_pin_n_i,
	// Sequencer signals
	ifr_seq_if.seq sq
);
	import ifr_pkg::*;

	localparam int CNT_W = $clog2(RESET_MIN_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_MIN = CNT_W'(RESET_MIN_CYCLES);

	ifr_seq_state_e state;
	ifr_seq_state_e next_state;
	logic p1;
	logic p2;
	logic p3;
	logic pin_high;
	logic [CNT_W-1:0] low_cnt;

	// =====================================================================
	// Pin synchroniser
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			p1 <= 1'b0;
			p2 <= 1'b0;
			p3 <= 1'b0;
		end else begin
			p1 <= reset_pin_n_i;
			p2 <= p1;
			p3 <= p2;
		end
	end

	// Power-up counts as a low pin until the filter sees a stable high.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pin_high <= 1'b0;
		end else if (p2 == p3) begin
			pin_high <= p3;
		end
	end

	// =====================================================================
	// Low-time counter, saturating at the minimum hold
	always_ff @(posedge core_clk_i) begin
		if (rst_i || next_state != SEQ_RESET || pin_high) begin
			low_cnt <= '0;
		end else if (low_cnt != CNT_MIN) begin
			low_cnt <= low_cnt + CNT_W'(1);
		end
	end

	// =====================================================================
	// Sequence control
	always_comb begin
		next_state = state;
		case (state)
			SEQ_RESET: begin
				if (pin_high && low_cnt == CNT_MIN) begin
					next_state = SEQ_MASK;
				end
			end
			SEQ_MASK: next_state = SEQ_VEC_REQ;
			SEQ_VEC_REQ: next_state = SEQ_VEC_WAIT;
			SEQ_VEC_WAIT: begin
				if (sq.vec_valid) begin
					next_state = SEQ_FIRST;
				end
			end
			SEQ_FIRST: begin
				if (sq.first_done) begin
					next_state = SEQ_RUN;
				end
			end
			SEQ_RUN: next_state = SEQ_RUN;
			default: next_state = SEQ_RESET;
		endcase
		if (!pin_high) begin
			next_state = SEQ_RESET;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= SEQ_RESET;
		end else begin
			state <= next_state;
		end
	end

	// =====================================================================
	// Registered outputs, decoded from the state and the next state
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sq.hold <= 1'b1;
			sq.init <= 1'b1;
			sq.mask_set <= 1'b0;
			sq.vec_rd <= 1'b0;
			sq.pc_load <= 1'b0;
			sq.irq_block <= 1'b1;
			sq.seq_done <= 1'b0;
			sq.short_reset <= 1'b0;
		end else begin
			sq.hold <= (next_state != SEQ_FIRST && next_state != SEQ_RUN);
			sq.init <= (next_state == SEQ_RESET);
			sq.mask_set <= (next_state == SEQ_MASK);
			sq.vec_rd <= (next_state == SEQ_VEC_REQ);
			sq.pc_load <= (state == SEQ_VEC_WAIT && next_state == SEQ_FIRST);
			sq.irq_block <= (next_state != SEQ_RUN);
			sq.seq_done <= (state == SEQ_FIRST && next_state == SEQ_RUN);
			// A release before the minimum hold leaves the device in reset.
			sq.short_reset <= (state == SEQ_RESET && pin_high && !sq.init
				&& low_cnt != CNT_MIN) || (state == SEQ_RESET && pin_high
				&& low_cnt != '0 && low_cnt != CNT_MIN);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sq.pc_value <= RST_PC;
		end else if (state == SEQ_VEC_WAIT && sq.vec_valid) begin
			sq.pc_value <= sq.vec_data;
		end
	end
endmodule // ifr_reset_seq

// ### design/ifr_flags.sv
// Top of the interrupt flag and reset entry block.
// Assumes peripheral event inputs are one-cycle pulses on the system clock,
// and pin inputs are asynchronous.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
module ifr_flags (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [ifr_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [ifr_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [ifr_pkg::DATA_W-1:0] reg_rdata_o,
	// Internal event sources
	input wire logic sleep_direct_xfer_i,
	input wire logic direct_transfer_enable_i,
	input wire logic timer_overflow_i,
	// External pins and their selection
	input wire logic [ifr_pkg::PIN_IRQS-1:0] irq_pin_i,
	input wire logic [ifr_pkg::PIN_IRQS-1:0] irq_pin_sel_i,
	input wire logic [ifr_pkg::PIN_IRQS-1:0] irq_edge_sel_i,
	input wire logic [ifr_pkg::WAKE_PINS-1:0] wakeup_pin_i,
	input wire logic [ifr_pkg::WAKE_PINS-1:0] wakeup_pin_sel_i,
	input wire logic [ifr_pkg::WAKE_PINS-1:0] wakeup_edge_sel_i,
	// Interrupt enables
	input wire logic direct_irq_enable_i,
	input wire logic timer_irq_enable_i,
	input wire logic wakeup_irq_enable_i,
	input wire logic [ifr_pkg::PIN_IRQS-1:0] irq_enable_i,
	// Reset pin
	input wire logic reset_pin_n_i,
	// CPU side
	input wire logic [15:0] vec_data_i,
	input wire logic vec_valid_i,
	input wire logic first_insn_done_i,
	output logic cpu_hold_o,
	output logic periph_init_o,
	output logic ccr_mask_set_o,
	output logic vec_rd_o,
	output logic [15:0] vec_addr_o,
	output logic pc_load_o,
	output logic [15:0] pc_value_o,
	output logic irq_accept_block_o,
	output logic cpu_irq_req_o,
	// Block interrupt
	output logic irq_o
);
	import ifr_pkg::*;

	ifr_seq_if sq ();

	logic direct_transition_flag;
	logic timer_overflow_flag;
	logic [PIN_IRQS-1:0] pin_flags;
	logic [WAKE_PINS-1:0] wakeup_request_flags;
	logic [PIN_IRQS-1:0] pin_edge;
	logic [WAKE_PINS-1:0] wake_edge;
	logic [EVT_BITS-1:0] evt_status;
	logic [EVT_BITS-1:0] evt_mask;
	logic [EVT_BITS-1:0] evt_set;
	logic wr_flags;
	logic wr_wake;
	logic [DATA_W-1:0] flags_view;
	logic [DATA_W-1:0] wake_view;
	logic [DATA_W-1:0] next_rdata;
	logic [WAKE_PINS-1:0] wake_keep;

	// =====================================================================
	// Reset entry sequencer
	assign sq.vec_data = vec_data_i;
	assign sq.vec_valid = vec_valid_i;
	assign sq.first_done = first_insn_done_i;

	ifr_reset_seq u_seq (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.reset_pin_n_i(reset_pin_n_i),
		.sq(sq.seq)
	);

	assign cpu_hold_o = sq.hold;
	assign periph_init_o = sq.init;
	assign ccr_mask_set_o = sq.mask_set;
	assign vec_rd_o = sq.vec_rd;
	assign pc_load_o = sq.pc_load;
	assign pc_value_o = sq.pc_value;
	assign irq_accept_block_o = sq.irq_block;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			vec_addr_o <= RESET_VECTOR_ADDR;
		end else begin
			vec_addr_o <= RESET_VECTOR_ADDR;
		end
	end

	// =====================================================================
	// Pin edge detectors
	genvar gi;
	generate
		for (gi = 0; gi < PIN_IRQS + WAKE_PINS; gi++) begin : g_pin
			if (gi < PIN_IRQS) begin : g_irq
				ifr_pin_edge u_edge (
					.core_clk_i(core_clk_i),
					.rst_i(rst_i),
					.pin_i(irq_pin_i[gi]),
					.rise_sel_i(irq_edge_sel_i[gi]),
					.edge_o(pin_edge[gi])
				);
			end else begin : g_wake
				ifr_pin_edge u_edge (
					.core_clk_i(core_clk_i),
					.rst_i(rst_i),
					.pin_i(wakeup_pin_i[gi-PIN_IRQS]),
					.rise_sel_i(wakeup_edge_sel_i[gi-PIN_IRQS]),
					.edge_o(wake_edge[gi-PIN_IRQS])
				);
			end
		end
	endgenerate

	// =====================================================================
	// Request flags
	// A write of one keeps the flag, a write of zero clears it, and a hardware
	// set in the same cycle wins so no event is lost.
	assign wr_flags = reg_wr_i && reg_addr_i == OFS_REQUEST_FLAGS;
	assign wr_wake = reg_wr_i && reg_addr_i == OFS_WAKEUP_FLAGS;
	assign wake_keep = wr_wake ? reg_wdata_i[WAKE_PINS-1:0] : {WAKE_PINS{1'b1}};

	always_ff @(posedge core_clk_i) begin
		if (rst_i || sq.init) begin
			direct_transition_flag <= RST_FLAGS[BIT_DIRECT_TRANSITION];
		end else if (sleep_direct_xfer_i && direct_transfer_enable_i) begin
			direct_transition_flag <= 1'b1;
		end else if (wr_flags && !reg_wdata_i[BIT_DIRECT_TRANSITION]) begin
			direct_transition_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || sq.init) begin
			timer_overflow_flag <= RST_FLAGS[BIT_TIMER_OVERFLOW];
		end else if (timer_overflow_i) begin
			timer_overflow_flag <= 1'b1;
		end else if (wr_flags && !reg_wdata_i[BIT_TIMER_OVERFLOW]) begin
			timer_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || sq.init) begin
			pin_flags <= RST_FLAGS[PIN_IRQS-1:0];
		end else begin
			pin_flags <= (pin_flags & (wr_flags ? reg_wdata_i[PIN_IRQS-1:0]
				: {PIN_IRQS{1'b1}})) | (pin_edge & irq_pin_sel_i);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || sq.init) begin
			wakeup_request_flags <= RST_FLAGS[WAKE_PINS-1:0];
		end else begin
			wakeup_request_flags <= (wakeup_request_flags & wake_keep)
				| (wake_edge & wakeup_pin_sel_i);
		end
	end

	// =====================================================================
	// CPU request, held off until the first instruction has run
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cpu_irq_req_o <= 1'b0;
		end else begin
			cpu_irq_req_o <= !sq.irq_block && (
				(direct_transition_flag && direct_irq_enable_i)
				|| (timer_overflow_flag && timer_irq_enable_i)
				|| |(pin_flags & irq_enable_i)
				|| (|wakeup_request_flags && wakeup_irq_enable_i));
		end
	end

	// =====================================================================
	// Block events: sticky, cleared by reading, set beats the read clear
	assign evt_set[BIT_EVT_SEQ_DONE] = sq.seq_done;
	assign evt_set[BIT_EVT_SHORT_RESET] = sq.short_reset;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			evt_status <= RST_EVENTS;
		end else if (reg_rd_i && reg_addr_i == OFS_EVENT_STATUS) begin
			evt_status <= evt_set;
		end else begin
			evt_status <= evt_status | evt_set;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			evt_mask <= RST_EVENTS;
		end else if (reg_wr_i && reg_addr_i == OFS_EVENT_MASK) begin
			evt_mask <= reg_wdata_i[EVT_BITS-1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((evt_status | evt_set) & evt_mask);
		end
	end

	// =====================================================================
	// Read data, one cycle after the read strobe
	always_comb begin
		flags_view = {direct_transition_flag, timer_overflow_flag, RSVD_READ_ONES,
			pin_flags};
		wake_view = {RSVD_READ_ONES, wakeup_request_flags};
		next_rdata = '0;
		case (reg_addr_i)
			OFS_REQUEST_FLAGS: next_rdata = flags_view;
			OFS_WAKEUP_FLAGS: next_rdata = wake_view;
			OFS_EVENT_STATUS: next_rdata = {{(DATA_W-EVT_BITS){1'b0}}, evt_status};
			OFS_EVENT_MASK: next_rdata = {{(DATA_W-EVT_BITS){1'b0}}, evt_mask};
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= '0;
		end
	end
endmodule // ifr_flags

// ### bench/ifr_cpu_model.sv
// CPU core stand-in that answers the vector read and reports the first instruction.
// Assumes vec_rd and pc_load are one-cycle pulses from the block under test.
`timescale 1ns/100ps
module ifr_cpu_model #(
	parameter logic [15:0] VECTOR = 16'h1234
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Answer delay in cycles
	input wire logic [3:0] delay_i,
	// From the block
	input wire logic vec_rd_i,
	input wire logic pc_load_i,
	// To the block
	output logic [15:0] vec_data_o,
	output logic vec_valid_o,
	output logic first_done_o
);
	// =====================================================================
	// Answer counters
	logic [4:0] vec_cnt;
	logic [4:0] run_cnt;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			vec_cnt <= 5'h00;
		end else if (vec_rd_i) begin
			vec_cnt <= {1'b0, delay_i} + 5'h01;
		end else if (vec_cnt != 5'h00) begin
			vec_cnt <= vec_cnt - 5'h01;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			run_cnt <= 5'h00;
		end else if (pc_load_i) begin
			run_cnt <= {1'b0, delay_i} + 5'h01;
		end else if (run_cnt != 5'h00) begin
			run_cnt <= run_cnt - 5'h01;
		end
	end

	// Outside the answer cycle the data bus shows the inverse, so a late sample is caught.
	assign vec_valid_o = (vec_cnt == 5'h01);
	assign vec_data_o = vec_valid_o ? VECTOR : ~VECTOR;
	assign first_done_o = (run_cnt == 5'h01);
endmodule // ifr_cpu_model

// ### bench/ifr_flags_chk.sv
// Port-level assertions for the flag and reset entry block.
// Assumes one clock and the synchronous active-high reset of the top module.
`timescale 1ns/100ps
module ifr_flags_chk (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [ifr_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [ifr_pkg::DATA_W-1:0] reg_rdata_o,
	// Events and enables
	input wire logic timer_overflow_i,
	input wire logic direct_irq_enable_i,
	input wire logic timer_irq_enable_i,
	input wire logic wakeup_irq_enable_i,
	input wire logic [ifr_pkg::PIN_IRQS-1:0] irq_enable_i,
	// Reset pin and CPU side
	input wire logic reset_pin_n_i,
	input wire logic [15:0] vec_data_i,
	input wire logic vec_valid_i,
	input wire logic first_insn_done_i,
	input wire logic cpu_hold_o,
	input wire logic periph_init_o,
	input wire logic ccr_mask_set_o,
	input wire logic vec_rd_o,
	input wire logic [15:0] vec_addr_o,
	input wire logic pc_load_o,
	input wire logic [15:0] pc_value_o,
	input wire logic irq_accept_block_o,
	input wire logic cpu_irq_req_o
);
	import ifr_pkg::*;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	wire logic any_en = direct_irq_enable_i | timer_irq_enable_i | wakeup_irq_enable_i |
		(|irq_enable_i);

	// =====================================================================
	// Reset entry
	sequence s_mask_step;
		ccr_mask_set_o;
	endsequence
	sequence s_vec_step;
		vec_rd_o && vec_addr_o == RESET_VECTOR_ADDR;
	endsequence
	property p_entry;
		s_mask_step |=> s_vec_step;
	endproperty
	a_entry: assert property (p_entry) else $error("vector read not after mask set");
	property p_vec_load;
		vec_valid_i && cpu_hold_o && !periph_init_o |=> pc_load_o && pc_value_o == $past(vec_data_i);
	endproperty
	a_vec_load: assert property (p_vec_load) else $error("vector not loaded");
	property p_hold_load;
		$fell(cpu_hold_o) |-> pc_load_o;
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("CPU ran without vector");
	property p_pin_reset;
		!reset_pin_n_i [*8] |-> cpu_hold_o && periph_init_o && irq_accept_block_o;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("not halted in reset");
	property p_block_first;
		$fell(irq_accept_block_o) |-> $past(first_insn_done_i);
	endproperty
	a_block_first: assert property (p_block_first) else $error("block left early");
	property p_req_blocked;
		irq_accept_block_o && $past(irq_accept_block_o) |-> !cpu_irq_req_o;
	endproperty
	a_req_blocked: assert property (p_req_blocked) else $error("request while blocked");

	// =====================================================================
	// Flags and requests
	property p_timer_req;
		timer_overflow_i && timer_irq_enable_i && !irq_accept_block_o && reset_pin_n_i
			##1 timer_irq_enable_i && !irq_accept_block_o |=> cpu_irq_req_o;
	endproperty
	a_timer_req: assert property (p_timer_req) else $error("no timer request");
	property p_no_enable;
		!any_en && !$past(any_en) |-> !cpu_irq_req_o;
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("request while disabled");
	property p_rsvd;
		reg_rd_i && reg_addr_i == OFS_REQUEST_FLAGS
			|=> reg_rdata_o[BIT_RSVD_HI:BIT_RSVD_LO] == RSVD_READ_ONES;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
endmodule // ifr_flags_chk

bind ifr_flags ifr_flags_chk u_chk (
	.core_clk_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .timer_overflow_i,
	.direct_irq_enable_i, .timer_irq_enable_i, .wakeup_irq_enable_i, .irq_enable_i,
	.reset_pin_n_i, .vec_data_i, .vec_valid_i, .first_insn_done_i, .cpu_hold_o,
	.periph_init_o, .ccr_mask_set_o, .vec_rd_o, .vec_addr_o, .pc_load_o, .pc_value_o,
	.irq_accept_block_o, .cpu_irq_req_o
);

// ### bench/tb.sv
// Self-checking bench for the flag and reset entry block.
// Assumes the CPU model answers vector reads and reports the first instruction; the bench drives all other inputs.
`timescale 1ns/100ps
module tb;
	import ifr_pkg::*;
	localparam logic [15:0] VECTOR = 16'h1234;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [ADDR_W-1:0] reg_addr_i = '0, off;
	logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o, base, bitv;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, reset_pin_n_i = 1'b0;
	logic sleep_direct_xfer_i = 1'b0, direct_transfer_enable_i = 1'b0, timer_overflow_i = 1'b0;
	logic [PIN_IRQS-1:0] irq_pin_i = '1, irq_pin_sel_i = '1, irq_edge_sel_i = '0, irq_enable_i = '0;
	logic [WAKE_PINS-1:0] wakeup_pin_i = '1, wakeup_pin_sel_i = '1, wakeup_edge_sel_i = '0;
	logic direct_irq_enable_i = 1'b0, timer_irq_enable_i = 1'b0, wakeup_irq_enable_i = 1'b0;
	logic [3:0] cpu_delay = 4'h0;
	logic [15:0] vec_data_i, vec_addr_o, pc_value_o;
	logic vec_valid_i, first_insn_done_i, cpu_hold_o, periph_init_o, ccr_mask_set_o, vec_rd_o;
	logic pc_load_o, irq_accept_block_o, cpu_irq_req_o, irq_o;
	int n_fail = 0, samples_checked = 0;

	ifr_flags dut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .sleep_direct_xfer_i, .direct_transfer_enable_i, .timer_overflow_i,
		.irq_pin_i, .irq_pin_sel_i, .irq_edge_sel_i, .wakeup_pin_i, .wakeup_pin_sel_i,
		.wakeup_edge_sel_i, .direct_irq_enable_i, .timer_irq_enable_i, .wakeup_irq_enable_i,
		.irq_enable_i, .reset_pin_n_i, .vec_data_i, .vec_valid_i, .first_insn_done_i,
		.cpu_hold_o, .periph_init_o, .ccr_mask_set_o, .vec_rd_o, .vec_addr_o, .pc_load_o,
		.pc_value_o, .irq_accept_block_o, .cpu_irq_req_o, .irq_o);
	ifr_cpu_model #(.VECTOR(VECTOR)) u_cpu (.core_clk_i, .rst_i, .delay_i(cpu_delay),
		.vec_rd_i(vec_rd_o), .pc_load_i(pc_load_o), .vec_data_o(vec_data_i),
		.vec_valid_o(vec_valid_i), .first_done_o(first_insn_done_i));

	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	// =====================================================================
	// Access and compare tasks
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0, got}, {15'h0, exp});
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk_val({8'h0, reg_rdata_o}, {8'h0, exp});
	endtask
	// Event pulses, optionally with a zero write to the flags in the same cycle.
	task automatic ev(input logic s, input logic t, input logic w);
		@(posedge core_clk_i);
		sleep_direct_xfer_i <= s;
		timer_overflow_i <= t;
		reg_wr_i <= w;
		reg_addr_i <= OFS_REQUEST_FLAGS;
		reg_wdata_i <= 8'h00;
		@(posedge core_clk_i);
		sleep_direct_xfer_i <= 1'b0;
		timer_overflow_i <= 1'b0;
		reg_wr_i <= 1'b0;
	endtask
	task automatic pin_drive(input int j, input logic v);
		@(posedge core_clk_i);
		if (j < PIN_IRQS) irq_pin_i[j] <= v;
		else wakeup_pin_i[j-PIN_IRQS] <= v;
		step(8);
	endtask
	task automatic end_test(input string name);
		$display("Test %s finished, %0d mismatches so far", name, n_fail);
	endtask
	task automatic stop_test();
		$display("Checked %0d values, %0d mismatches", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic run_seq(input logic [3:0] dly);
		int k;
		@(posedge core_clk_i);
		cpu_delay <= dly;
		reset_pin_n_i <= 1'b0;
		repeat (12) @(posedge core_clk_i);
		reset_pin_n_i <= 1'b1;
		k = 0;
		while (ccr_mask_set_o !== 1'b1 && k < 40) begin
			step(1);
			k++;
		end
		chk_bit(ccr_mask_set_o, 1'b1);
		step(1);
		chk_bit(vec_rd_o, 1'b1);
		chk_val(vec_addr_o, RESET_VECTOR_ADDR);
		for (k = 0; k < 20 && pc_load_o !== 1'b1; k++) step(1);
		chk_bit(pc_load_o, 1'b1);
		chk_val(pc_value_o, VECTOR);
		chk_bit(cpu_hold_o, 1'b0);
		chk_bit(irq_accept_block_o, 1'b1);
		for (k = 0; k < 20 && irq_accept_block_o !== 1'b0; k++) step(1);
		chk_bit(irq_accept_block_o, 1'b0);
		end_test("reset entry");
	endtask

	initial begin
		#150000;
		n_fail++;
		$display("Error at %0t: watchdog expired", $time);
		stop_test();
	end

	// =====================================================================
	// Test sequence
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		run_seq(4'h0);
		rd_chk(OFS_REQUEST_FLAGS, 8'h30);
		rd_chk(OFS_WAKEUP_FLAGS, 8'hc0);
		wr(OFS_EVENT_MASK, 8'h03);
		step(1);
		chk_bit(irq_o, 1'b1);
		rd_chk(OFS_EVENT_STATUS, 8'h01);
		step(1);
		chk_bit(irq_o, 1'b0);
		end_test("event status");
		@(posedge core_clk_i);
		timer_irq_enable_i <= 1'b1;
		direct_irq_enable_i <= 1'b1;
		ev(1'b1, 1'b0, 1'b0);
		rd_chk(OFS_REQUEST_FLAGS, 8'h30);
		@(posedge core_clk_i);
		direct_transfer_enable_i <= 1'b1;
		ev(1'b1, 1'b1, 1'b0);
		rd_chk(OFS_REQUEST_FLAGS, 8'hf0);
		chk_bit(cpu_irq_req_o, 1'b1);
		@(posedge core_clk_i);
		direct_irq_enable_i <= 1'b0;
		timer_irq_enable_i <= 1'b0;
		step(2);
		chk_bit(cpu_irq_req_o, 1'b0);
		@(posedge core_clk_i);
		direct_irq_enable_i <= 1'b1;
		timer_irq_enable_i <= 1'b1;
		wr(OFS_REQUEST_FLAGS, 8'hff);
		rd_chk(OFS_REQUEST_FLAGS, 8'hf0);
		wr(OFS_REQUEST_FLAGS, 8'h7f);
		rd_chk(OFS_REQUEST_FLAGS, 8'h70);
		ev(1'b0, 1'b1, 1'b1);
		rd_chk(OFS_REQUEST_FLAGS, 8'h70);
		wr(4'hf, 8'h00);
		rd_chk(4'hf, 8'h00);
		rd_chk(OFS_REQUEST_FLAGS, 8'h70);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		rd_chk(OFS_REQUEST_FLAGS, 8'h30);
		end_test("request flags");
		@(posedge core_clk_i);
		irq_enable_i <= '1;
		wakeup_irq_enable_i <= 1'b1;
		irq_edge_sel_i <= 4'ha;
		wakeup_edge_sel_i <= 6'h2a;
		for (int j = 0; j < PIN_IRQS + WAKE_PINS; j++) begin
			base = (j < PIN_IRQS) ? 8'h30 : 8'hc0;
			off = (j < PIN_IRQS) ? OFS_REQUEST_FLAGS : OFS_WAKEUP_FLAGS;
			bitv = 8'h01 << ((j < PIN_IRQS) ? j : j - PIN_IRQS);
			pin_drive(j, 1'b0);
			rd_chk(off, j[0] ? base : (base | bitv));
			pin_drive(j, 1'b1);
			rd_chk(off, base | bitv);
			chk_bit(cpu_irq_req_o, 1'b1);
			wr(off, 8'h00);
			rd_chk(off, base);
		end
		// A pin not selected for interrupt input must not set its flag.
		@(posedge core_clk_i);
		irq_pin_sel_i <= '0;
		wakeup_pin_sel_i <= '0;
		pin_drive(0, 1'b0);
		pin_drive(PIN_IRQS, 1'b0);
		rd_chk(OFS_REQUEST_FLAGS, 8'h30);
		rd_chk(OFS_WAKEUP_FLAGS, 8'hc0);
		pin_drive(0, 1'b1);
		pin_drive(PIN_IRQS, 1'b1);
		end_test("pin edges");
		wr(OFS_EVENT_MASK, 8'h01);
		ev(1'b0, 1'b1, 1'b0);
		@(posedge core_clk_i);
		reset_pin_n_i <= 1'b0;
		repeat (7) @(posedge core_clk_i);
		reset_pin_n_i <= 1'b1;
		step(10);
		chk_bit(cpu_hold_o, 1'b1);
		chk_bit(periph_init_o, 1'b1);
		chk_bit(irq_o, 1'b0);
		rd_chk(OFS_REQUEST_FLAGS, 8'h30);
		wr(OFS_EVENT_MASK, 8'h02);
		step(1);
		chk_bit(irq_o, 1'b1);
		rd_chk(OFS_EVENT_STATUS, 8'h02);
		step(1);
		chk_bit(irq_o, 1'b0);
		end_test("short reset");
		run_seq(4'h5);
		stop_test();
	end
endmodule // tb
